// >>> common/asrm_defines.vh
// Constants for the serial result readout block
`ifndef ASRM_DEFINES_VH
`define ASRM_DEFINES_VH

// Clock period of clk in ns
`define ASRM_CLK_PERIOD_NS   4
// Status test delay in ns and as a least count of cycles
`define ASRM_TEOC_NS         500
`define ASRM_TEOC_CYC        ((`ASRM_TEOC_NS + `ASRM_CLK_PERIOD_NS - 1) / `ASRM_CLK_PERIOD_NS)
// Half period of the generated serial clock in clk cycles
`define ASRM_SCK_HALF_CYC    8

// Frame length and speed code capture
`define ASRM_FRAME_BITS      32
`define ASRM_CODE_BITS       5
`define ASRM_CODE_RISES      5

// Synchronised pin vector positions
`define ASRM_PIN_SEL_N       0
`define ASRM_PIN_SCK         1
`define ASRM_PIN_SDI         2
`define ASRM_PIN_CLK_SRC     3
`define ASRM_PIN_COUNT       4

// One-hot state codes
`define ASRM_ST_CONV         4'h1
`define ASRM_ST_SLEEP        4'h2
`define ASRM_ST_WAIT         4'h4
`define ASRM_ST_SHIFT        4'h8

// Reset values
`define ASRM_RST_CODE        5'h00

`endif

// >>> logic/asrm_readout.v
// Serial result readout and conversion handshake of a delta-sigma converter
// Operation
// - External mode drives pending flag on output
// - Flag and busy high converting, low asleep
// - Result loads into shift register at completion
// - Sleep until first rising clock; shift on falls
// - Output and busy rise on 32nd fall
// - Internal mode: output hi-Z while select high
// - Select fall drives clock low, shows flag
// - Busy low from completion until readout
// - Clock starts 500ns after select or done
// - Early select rise keeps device asleep
// - Device drives clock; 32 rising edges per frame
// - After 32nd rise: output high, clock high, convert
// - Select rise mid frame aborts, starts conversion
// - Five rises needed before abort for code; here an earlier abort still loads the bits taken so far
// - Continuous: all three high converting, low asleep
// - Continuous: output starts 500ns after completion
// - Continuous: after 32nd rise output, clock high
// - Speed code sampled on rises, MSB first
`timescale 1ns/1ps
`include "asrm_defines.vh"
`default_nettype none

module asrm_readout #(
  parameter TEOC_CYC     = `ASRM_TEOC_CYC,
  parameter SCK_HALF_CYC = `ASRM_SCK_HALF_CYC
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        clock_source_select,
  input  wire        select_n,
  input  wire        sck_in,
  input  wire        sdi,
  input  wire        conv_done,
  input  wire [30:0] conv_result,
  output reg         conv_start,
  output reg  [4:0]  oversample_ratio,
  output reg         busy,
  output reg         sdo_out,
  output reg         sdo_oe,
  output reg         sck_out,
  output reg         sck_oe
);

  localparam [3:0] ST_CONV  = `ASRM_ST_CONV;
  localparam [3:0] ST_SLEEP = `ASRM_ST_SLEEP;
  localparam [3:0] ST_WAIT  = `ASRM_ST_WAIT;
  localparam [3:0] ST_SHIFT = `ASRM_ST_SHIFT;
  // Integer forms first, then cut to the counter widths on purpose
  localparam integer TEOC_M1  = TEOC_CYC - 1;
  localparam integer HALF_M1  = SCK_HALF_CYC - 1;
  localparam integer FRAME_I  = `ASRM_FRAME_BITS;
  localparam integer FALLS_M1 = `ASRM_FRAME_BITS - 1;
  localparam integer RISES_I  = `ASRM_CODE_RISES;
  localparam [7:0] TEOC_LAST  = TEOC_M1[7:0];
  localparam [7:0] HALF_LAST  = HALF_M1[7:0];
  localparam [5:0] FRAME_LEN  = FRAME_I[5:0];
  localparam [5:0] LAST_EDGE  = FALLS_M1[5:0];
  localparam [5:0] CODE_RISES = RISES_I[5:0];

  // Three-stage pin synchronisers plus agreement filter
  reg  [3:0]  pin_s1;
  reg  [3:0]  pin_s2;
  reg  [3:0]  pin_s3;
  reg  [3:0]  pin_f;
  reg  [3:0]  pin_fd;

  reg  [3:0]  state;
  reg  [7:0]  wait_cnt;
  reg  [7:0]  div_cnt;
  reg  [5:0]  rise_cnt;
  reg  [5:0]  fall_cnt;
  reg  [31:0] shift;
  reg  [4:0]  code_sh;
  reg         started;

  wire [3:0] pin_raw  = {clock_source_select, sdi, sck_in, select_n};
  wire [3:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire       sel_f    = pin_f[`ASRM_PIN_SEL_N];
  wire       sel_rise = pin_f[`ASRM_PIN_SEL_N] & ~pin_fd[`ASRM_PIN_SEL_N];
  wire       sel_fall = ~pin_f[`ASRM_PIN_SEL_N] & pin_fd[`ASRM_PIN_SEL_N];
  wire       xsck_rise = pin_f[`ASRM_PIN_SCK] & ~pin_fd[`ASRM_PIN_SCK];
  wire       xsck_fall = ~pin_f[`ASRM_PIN_SCK] & pin_fd[`ASRM_PIN_SCK];
  wire       sdi_f    = pin_f[`ASRM_PIN_SDI];
  // Sampled continuously; a change mid frame is not guarded
  // static clock source
  wire       int_mode = pin_f[`ASRM_PIN_CLK_SRC];

  wire       in_shift = (state == ST_SHIFT);
  wire       div_hit  = int_mode & in_shift & (div_cnt == HALF_LAST);
  wire       int_rise = div_hit & ~sck_out;
  wire       int_fall = div_hit & sck_out;
  wire       rise_ev  = in_shift & (int_mode ? int_rise : xsck_rise);
  wire       fall_ev  = in_shift & (int_mode ? int_fall : xsck_fall);

  wire       abort    = in_shift & sel_rise;
  wire       ext_end  = ~int_mode & fall_ev & (fall_cnt == LAST_EDGE);
  // Ends half a period after the 32nd rise so the last bit stands through it
  // end after 32nd rise
  wire       int_end  = int_mode & int_fall & (rise_cnt == FRAME_LEN);
  wire       frame_end = abort | ext_end | int_end;
  // Entry into a frame from either clock source
  wire       wait_done  = (state == ST_WAIT) & ~sel_f & (wait_cnt == TEOC_LAST);
  wire       ext_first  = (state == ST_SLEEP) & ~int_mode & xsck_rise;
  wire       first_rise = wait_done | ext_first;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1           <= 4'h0;
      pin_s2           <= 4'h0;
      pin_s3           <= 4'h0;
      pin_f            <= 4'h0;
      pin_fd           <= 4'h0;
    end
    else
    begin
      pin_s1           <= pin_raw;
      pin_s2           <= pin_s1;
      pin_s3           <= pin_s2;
      pin_f            <= (pin_agree & pin_s3) | (~pin_agree & pin_f);
      pin_fd           <= pin_f;
    end
  end

  // Output enables follow the synchronised pins
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdo_oe <= 1'b0;
      sck_oe <= 1'b0;
    end
    else
    begin
      sdo_oe <= ~sel_f;
      sck_oe <= int_mode;
    end
  end

  // One start pulse after reset release, then one per frame end
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      started    <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      started    <= 1'b1;
      conv_start <= ~started | frame_end;
    end
  end

  // Half period divider; div_hit is the enable of each internal clock edge after the first rise, which wait_done sets
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_cnt <= 8'h00;
    else if (!in_shift || frame_end || div_hit)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wait_cnt <= 8'h00;
    else if (state != ST_WAIT)
      wait_cnt <= 8'h00;
    else if (wait_cnt != TEOC_LAST)
      wait_cnt <= wait_cnt + 8'h01;
  end

  // Edge counters of the current frame
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rise_cnt <= 6'h00;
      fall_cnt <= 6'h00;
    end
    else if (first_rise)
    begin
      rise_cnt <= 6'h01;
      fall_cnt <= 6'h00;
    end
    else if (in_shift && !frame_end)
    begin
      if (rise_ev)
        rise_cnt <= rise_cnt + 6'h01;
      if (fall_ev)
        fall_cnt <= fall_cnt + 6'h01;
    end
  end

  // Speed code capture; applied to the conversion that the frame end starts
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      code_sh          <= `ASRM_RST_CODE;
      oversample_ratio <= `ASRM_RST_CODE;
    end
    else if (first_rise)
    begin
      code_sh <= {4'h0, sdi_f};
    end
    else if (frame_end)
    begin
      oversample_ratio <= code_sh;
    end
    else if (rise_ev && (rise_cnt < CODE_RISES))
    begin
      code_sh <= {code_sh[3:0], sdi_f};
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state   <= ST_CONV;
      shift   <= 32'h00000000;
      busy    <= 1'b1;
      sdo_out <= 1'b1;
      sck_out <= 1'b1;
    end
    else
    begin
      case (state)
        ST_CONV:
        begin
          busy    <= 1'b1;
          sdo_out <= 1'b1;
          if (int_mode && sel_fall)
            sck_out <= 1'b0;
          if (conv_done)
          begin
            shift   <= {1'b0, conv_result};
            state   <= ST_SLEEP;
            busy    <= 1'b0;
            sdo_out <= 1'b0;
            sck_out <= 1'b0;
          end
        end
        ST_SLEEP:
        begin
          busy <= 1'b0;
          if (ext_first)
          begin
            state <= ST_SHIFT;
          end
          else if (int_mode && !sel_f)
          begin
            state   <= ST_WAIT;
            sck_out <= 1'b0;
          end
        end
        ST_WAIT:
        begin
          if (sel_f)
          begin
            state <= ST_SLEEP;
          end
          else if (wait_done)
          begin
            state   <= ST_SHIFT;
            sck_out <= 1'b1;
          end
        end
        ST_SHIFT:
        begin
          if (frame_end)
          begin
            state   <= ST_CONV;
            busy    <= 1'b1;
            sdo_out <= 1'b1;
            sck_out <= 1'b1;
          end
          else
          begin
            if (fall_ev)
            begin
              shift   <= {shift[30:0], 1'b0};
              sdo_out <= shift[30];
              if (int_mode)
                sck_out <= 1'b0;
            end
            // Generated clock rises only on the divider enable
            if (rise_ev && int_mode)
              sck_out <= 1'b1;
          end
        end
        default:
        begin
          state <= ST_CONV;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> testbench/asrm_host.sv
// External serial host that clocks results out in external clock mode
`timescale 1ns/1ps
`default_nettype none
module asrm_host (
  input  wire logic sdo_line,
  output logic      sck_drv,
  output logic      sdi
);
  // Clock stands low between frames
  initial sck_drv = 1'b0;
  initial sdi = 1'b0;
  // code MSB first, data latched on rises
  task automatic frame(input logic [4:0] code, input int half, output logic [31:0] got);
    for (int i = 0; i < 32; i++)
    begin
      sdi = (i < 5) ? code[4 - i] : 1'b0;
      #(half) sck_drv = 1'b1;
      got = {got[30:0], sdo_line};
      #(half) sck_drv = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/asrm_readout_chk.sv
// Port assertions of the serial readout block
`timescale 1ns/1ps
`default_nettype none
module asrm_readout_chk #(
  parameter TEOC_CYC = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic select_n,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic busy,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sck_out,
  input wire logic sck_oe
);
  // Lower bound allows for the cycle spent entering sleep
  localparam int TW = TEOC_CYC - 1;
  localparam int TX = TEOC_CYC + 12;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_done;
    sck_oe && $fell(busy);
  endsequence
  chk_done_sleep: assert property (conv_done && busy |=> !busy && !sdo_out)
    else $error("no sleep after done");
  chk_start_busy: assert property ($rose(busy) |-> conv_start || $past(conv_start))
    else $error("busy without start");
  chk_busy_hold: assert property ($fell(busy) |-> !busy[*4])
    else $error("busy rose early");
  chk_teoc_wait: assert property (s_done |-> !sck_out[*8])
    else $error("clock too early");
  chk_auto_start: assert property (s_done ##0 sdo_oe |-> ##[TW:TX] sck_out)
    else $error("no clock after wait");
  chk_conv_high: assert property (busy && $past(busy) |-> sdo_out && (sck_out || !sck_oe))
    else $error("lines low converting");
  chk_sdo_hiz: assert property (select_n[*6] |-> !sdo_oe)
    else $error("sdo driven deselected");
  chk_sel_drive: assert property ($fell(select_n) ##1 !select_n[*5] |-> sdo_oe)
    else $error("sdo not driven");
  chk_sleep_quiet: assert property ((sck_oe && !busy && select_n)[*6] |-> !sck_out)
    else $error("clock left sleep");
endmodule
bind asrm_readout asrm_readout_chk #(.TEOC_CYC(TEOC_CYC)) asrm_readout_chk_inst (
  .clk(clk), .reset_n(reset_n), .select_n(select_n), .conv_done(conv_done),
  .conv_start(conv_start), .busy(busy), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
  .sck_out(sck_out), .sck_oe(sck_oe));
`default_nettype wire

// >>> testbench/asrm_readout_test.sv
// Self-checking bench for the serial readout block
`timescale 1ns/1ps
`default_nettype none
module asrm_readout_test;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        css = 1'b0;
  logic        select_n = 1'b0;
  logic        conv_done = 1'b0;
  logic        sdo_q = 1'b0;
  logic [30:0] res = 31'h0;
  logic [31:0] got;
  int          fails = 0;
  int          total_checks = 0;
  wire         conv_start, busy, sdo_out, sdo_oe, sck_out, sck_oe, sck_drv, sdi;
  wire   [4:0] ratio;
  // Released data line shows the inverse of its last level
  wire         sdo_ln = sdo_oe ? sdo_out : ~sdo_q;
  wire         sck_ln = sck_oe ? sck_out : sck_drv;
  always #2 clk = ~clk;
  always @(posedge clk)
    if (sdo_oe)
      sdo_q <= sdo_out;
  asrm_readout #(.TEOC_CYC(16), .SCK_HALF_CYC(4)) asrm_readout_inst (
    .clk(clk), .reset_n(reset_n), .clock_source_select(css), .select_n(select_n),
    .sck_in(sck_ln), .sdi(sdi), .conv_done(conv_done), .conv_result(res),
    .conv_start(conv_start), .oversample_ratio(ratio), .busy(busy), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sck_out(sck_out), .sck_oe(sck_oe));
  asrm_host asrm_host_inst (.sdo_line(sdo_ln), .sck_drv(sck_drv), .sdi(sdi));
  task automatic give_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst(input logic mode);
    reset_n = 1'b0;
    css = mode;
    tick(16);
    reset_n = 1'b1;
    tick(8);
  endtask
  task automatic complete(input logic [30:0] r);
    tick(4);
    res = r;
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
    tick(1);
    cmp({busy, sdo_out}, 32'h0);
  endtask
  task automatic hold(input logic v);
    int k;
    k = 0;
    while (sck_out !== v && k < 300)
    begin
      tick(1);
      k++;
    end
    if (k == 300)
    begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic grab(input logic [4:0] code, input int n);
    for (int i = 0; i < n; i++)
    begin
      asrm_host_inst.sdi = (i < 5) ? code[4 - i] : 1'b0;
      hold(1'b0);
      hold(1'b1);
      got = {got[30:0], sdo_ln};
    end
  endtask
  task automatic t_ext();
    rst(1'b0);
    cmp({sdo_oe, sdo_out}, 32'h3);
    complete(31'h2d2d_091a);
    asrm_host_inst.frame(5'h13, 40, got);
    cmp(got, {1'b0, 31'h2d2d_091a});
    tick(8);
    cmp({busy, sdo_out, ratio}, {2'b11, 5'h13});
  endtask
  task automatic t_int();
    select_n = 1'b1;
    rst(1'b1);
    complete(31'h5b1c_e3a7);
    cmp(sdo_oe, 32'h0);
    select_n = 1'b0;
    tick(6);
    cmp({sdo_oe, sdo_out, sck_out}, 32'h4);
    select_n = 1'b1;
    tick(40);
    cmp({busy, sck_out}, 32'h0);
    select_n = 1'b0;
    grab(5'h16, 32);
    cmp(got, {1'b0, 31'h5b1c_e3a7});
    tick(10);
    cmp({busy, sdo_out, sck_out, ratio}, {3'h7, 5'h16});
    complete(31'h5555_5555);
    grab(5'h14, 3);
    cmp(got[2:0], 32'h2);
    select_n = 1'b1;
    tick(6);
    cmp({busy, sdo_out, sck_out, ratio}, {3'h7, 5'h05});
  endtask
  task automatic t_cont();
    // Continuous mode: select low from reset on, never toggled
    select_n = 1'b0;
    rst(1'b1);
    complete(31'h0f0f_a5c3);
    grab(5'h09, 32);
    cmp(got, {1'b0, 31'h0f0f_a5c3});
    tick(10);
    cmp({busy, sdo_out, sck_out, ratio}, {3'h7, 5'h09});
  endtask
  initial
  begin
    t_ext();
    t_int();
    t_cont();
    give_verdict();
  end
endmodule
`default_nettype wire
